/* bed_decoder.sv */
// branch and escape decode slice: byte-per-clock sequencer
`timescale 1ns/1ps
`include "bed_consts.svh"
// Summary of operation
// - A5 byte is escape prefix
// - shift right moves bits 39 to 1 down one place
// - shift keeps bit 39, flags untouched
// - breakpoint halts to debug when enabled
// - breakpoint leaves pc plus two
// - breakpoint disabled is two-cycle nop
// - escaped compare uses ram at ri
// - relative target is pc plus displacement
// - escaped compare sets carry when acc below operand
// - compare leaves operands unchanged
// - clear zeroes forty bits, flags untouched
// - compare jump: three bytes, four cycles
// - data pointer access two or four cycles, three or five escaped
// - stack ops longer with extended stack
// - alternate pointer is unselected one
module bed_decoder (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // program byte stream
    input wire logic [7:0] code_byte,
    input wire logic [15:0] pc_start,
    // core context and data pointers
    input wire bed_pkg::bed_ctx_t ctx,
    input wire logic [15:0] dptr0,
    input wire logic [15:0] dptr1,
    // multiplier result loaded into the accumulate register
    input wire logic mac_load,
    input wire logic [39:0] mac_load_val,
    // results
    output logic [15:0] pc_r,
    output logic [39:0] mac_acc_r,
    output logic carry_r,
    output logic carry_we_r,
    output logic debug_halt_r,
    output logic [15:0] xaddr_r,
    output logic busy_r
);
    bed_pkg::bed_state_t state_r;
    bed_pkg::bed_kind_t kind_r;
    logic [3:0] wait_r;
    logic esc_r;
    logic neq_r;
    logic started_r;
    logic [15:0] pc_nxt;

    // alternate pointer is whichever the select bit leaves out
    function automatic logic [15:0] alt_ptr(input logic sel, input logic [15:0] p0,
                                            input logic [15:0] p1);
        alt_ptr = sel ? p0 : p1;
    endfunction

    // pc advances one per fetched byte
    assign pc_nxt = pc_r + 16'h0001;

    // ************************************************
    // sequencer
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= bed_pkg::BED_ST_OP;
            kind_r <= bed_pkg::BED_K_NONE;
            wait_r <= 4'h0;
            esc_r <= 1'b0;
            neq_r <= 1'b0;
            started_r <= 1'b0;
            pc_r <= 16'h0000;
            carry_r <= 1'b0;
            carry_we_r <= 1'b0;
            debug_halt_r <= 1'b0;
            xaddr_r <= 16'h0000;
            busy_r <= 1'b0;
        end else if (!started_r) begin
            // pc is loaded one clock after release, never under reset
            started_r <= 1'b1;
            pc_r <= pc_start;
        end else if (debug_halt_r) begin
            // halted; the debug unit takes over from here
            debug_halt_r <= 1'b1;
        end else begin
            carry_we_r <= 1'b0;
            case (state_r)
                bed_pkg::BED_ST_OP: begin
                    pc_r <= pc_nxt;
                    esc_r <= 1'b0;
                    busy_r <= 1'b1;
                    if (code_byte == `BED_OP_ESCAPE) begin
                        state_r <= bed_pkg::BED_ST_ESC;
                    end else if (code_byte == `BED_OP_CJ_IMM || code_byte == `BED_OP_CJ_DIR
                                 || code_byte[7:1] == 7'h5b || code_byte[7:3] == 5'h17) begin
                        // plain compare forms: operand, then displacement
                        kind_r <= bed_pkg::BED_K_COMPARE_JUMP_NOT_EQUAL;
                        state_r <= bed_pkg::BED_ST_ARG1;
                    end else if (code_byte == `BED_OP_SJMP) begin
                        kind_r <= bed_pkg::BED_K_REL;
                        state_r <= bed_pkg::BED_ST_ARG2;
                    end else if (code_byte == `BED_OP_MOVX_RD || code_byte == `BED_OP_MOVX_WR) begin
                        kind_r <= bed_pkg::BED_K_EXTERNAL_DATA_SPACE;
                        xaddr_r <= ctx.pointer_select ? dptr1 : dptr0;
                        // the opcode cycle counts as one, the rest are wait cycles
                        wait_r <= (ctx.slow_space ? `BED_CYC_XSLOW : `BED_CYC_XRAM)
                                  - 4'h1;
                        state_r <= bed_pkg::BED_ST_WAIT;
                    end else if (code_byte == `BED_OP_RET) begin
                        kind_r <= bed_pkg::BED_K_STACK;
                        wait_r <= (ctx.ext_stack ? `BED_CYC_RET_EXT : `BED_CYC_RET)
                                  - 4'h1;
                        state_r <= bed_pkg::BED_ST_WAIT;
                    end else if (code_byte == `BED_OP_LCALL) begin
                        kind_r <= bed_pkg::BED_K_STACK;
                        wait_r <= (ctx.ext_stack ? `BED_CYC_LCALL_EXT : `BED_CYC_LCALL)
                                  - 4'h1;
                        state_r <= bed_pkg::BED_ST_WAIT;
                    end else begin
                        busy_r <= 1'b0;
                    end
                end
                bed_pkg::BED_ST_ESC: begin
                    pc_r <= pc_nxt;
                    esc_r <= 1'b1;
                    busy_r <= 1'b0;
                    state_r <= bed_pkg::BED_ST_OP;
                    case (code_byte)
                        `BED_OP_BREAK: begin
                            debug_halt_r <= ctx.debug_enable;
                        end
                        `BED_OP_COMPARE_JUMP_NOT_EQUAL_R0, `BED_OP_COMPARE_JUMP_NOT_EQUAL_R1: begin
                            // unsigned compare against ram at r0/r1, nothing written back
                            neq_r <= ctx.acc != ctx.ram_at_ri;
                            carry_r <= ctx.acc < ctx.ram_at_ri;
                            carry_we_r <= 1'b1;
                            kind_r <= bed_pkg::BED_K_COMPARE_JUMP_NOT_EQUAL;
                            busy_r <= 1'b1;
                            state_r <= bed_pkg::BED_ST_ARG2;
                        end
                        `BED_OP_MOVX_RD, `BED_OP_MOVX_WR: begin
                            xaddr_r <= alt_ptr(ctx.pointer_select, dptr0, dptr1);
                            wait_r <= (ctx.slow_space ? `BED_CYC_XSLOW : `BED_CYC_XRAM)
                                      - 4'h1;
                            kind_r <= bed_pkg::BED_K_EXTERNAL_DATA_SPACE;
                            busy_r <= 1'b1;
                            state_r <= bed_pkg::BED_ST_WAIT;
                        end
                        default: begin
                            // shift, clear and unknown codes end in two cycles
                            busy_r <= 1'b0;
                        end
                    endcase
                end
                bed_pkg::BED_ST_ARG1: begin
                    // operand byte of plain compare forms is consumed elsewhere
                    pc_r <= pc_nxt;
                    state_r <= bed_pkg::BED_ST_ARG2;
                end
                bed_pkg::BED_ST_ARG2: begin
                    pc_r <= pc_nxt;
                    state_r <= bed_pkg::BED_ST_WAIT;
                    wait_r <= 4'h0;
                    if (kind_r == bed_pkg::BED_K_REL || (kind_r == bed_pkg::BED_K_COMPARE_JUMP_NOT_EQUAL
                        && (!esc_r || neq_r))) begin
                        // displacement is relative to the next instruction
                        pc_r <= pc_nxt + {{8{code_byte[7]}}, code_byte};
                    end
                end
                bed_pkg::BED_ST_WAIT: begin
                    // redirect or access cycles with no fetch
                    if (wait_r <= 4'h1) begin
                        state_r <= bed_pkg::BED_ST_OP;
                        busy_r <= 1'b0;
                        kind_r <= bed_pkg::BED_K_NONE;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
                default: begin
                    state_r <= bed_pkg::BED_ST_OP;
                end
            endcase
        end
    end

    // ************************************************
    // forty-bit accumulate register
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mac_acc_r <= `BED_ACC_RST;
        end else if (started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC) begin
            if (code_byte == `BED_OP_ASR) begin
                mac_acc_r <= {mac_acc_r[39], mac_acc_r[39:1]};
            end else if (code_byte == `BED_OP_CLR) begin
                mac_acc_r <= `BED_ACC_RST;
            end
        end else if (mac_load) begin
            // a load during an escape decode cycle is dropped; the core never overlaps them
            mac_acc_r <= mac_load_val;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    asr_sign_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && code_byte == `BED_OP_ASR |=> mac_acc_r[39] == $past(mac_acc_r[39])
        && mac_acc_r[38:0] == $past(mac_acc_r[39:1]))
        else $error("shift right lost sign or bits");
    acc_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && code_byte == `BED_OP_CLR |=> mac_acc_r == 40'h00_0000_0000)
        else $error("clear left bits set");
    escape_seen_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_OP
        && code_byte == 8'ha5 |=> state_r == bed_pkg::BED_ST_ESC)
        else $error("escape byte not recognised");
    break_halt_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && code_byte == 8'h00 && ctx.debug_enable |=> debug_halt_r)
        else $error("breakpoint did not halt");
    break_pc_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_OP
        && code_byte == 8'ha5 ##1 code_byte == 8'h00
        |=> pc_r == $past(pc_r, 2) + 16'h0002)
        else $error("breakpoint pc not advanced by two");
    break_nop_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && code_byte == 8'h00 && !ctx.debug_enable
        |=> !debug_halt_r && !carry_we_r && state_r == bed_pkg::BED_ST_OP)
        else $error("disabled breakpoint not a plain nop");
    compare_jump_not_equal_carry_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && code_byte[7:1] == 7'h5b |=> carry_we_r
        && carry_r == ($past(ctx.acc) < $past(ctx.ram_at_ri)))
        else $error("compare carry wrong");
    compare_jump_not_equal_cycles_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_OP
        && code_byte == 8'hb4 |=> ##2 state_r == bed_pkg::BED_ST_WAIT
        ##1 state_r == bed_pkg::BED_ST_OP)
        else $error("compare jump not four cycles");
    unknown_esc_a: assert property (@(posedge clk_sys) disable iff (reset)
        started_r && !debug_halt_r && state_r == bed_pkg::BED_ST_ESC
        && !(code_byte inside {`BED_OP_BREAK, `BED_OP_ASR, `BED_OP_CLR, `BED_OP_COMPARE_JUMP_NOT_EQUAL_R0,
            `BED_OP_COMPARE_JUMP_NOT_EQUAL_R1, `BED_OP_MOVX_RD, `BED_OP_MOVX_WR})
        |=> state_r == bed_pkg::BED_ST_OP && !busy_r)
        else $error("unknown escape not a two-cycle nop");
    cover_asr_c: cover property (@(posedge clk_sys) state_r == bed_pkg::BED_ST_ESC
        && code_byte == `BED_OP_ASR);
    cover_break_c: cover property (@(posedge clk_sys) debug_halt_r);
    cover_compare_jump_not_equal_c: cover property (@(posedge clk_sys) carry_we_r && neq_r);
endmodule // bed_decoder

/* bed_consts.svh */
// timing counts and opcode constants for the branch and escape decoder
`ifndef BED_CONSTS_SVH
`define BED_CONSTS_SVH
`define BED_OP_ESCAPE 8'ha5
`define BED_OP_BREAK 8'h00
`define BED_OP_ASR 8'h03
`define BED_OP_CLR 8'he4
`define BED_OP_COMPARE_JUMP_NOT_EQUAL_R0 8'hb6
`define BED_OP_COMPARE_JUMP_NOT_EQUAL_R1 8'hb7
`define BED_OP_CJ_DIR 8'hb5
`define BED_OP_CJ_IMM 8'hb4
`define BED_OP_SJMP 8'h80
`define BED_OP_MOVX_RD 8'he0
`define BED_OP_MOVX_WR 8'hf0
`define BED_OP_RET 8'h22
`define BED_OP_LCALL 8'h12
`define BED_CYC_BREAK 4'h2
`define BED_CYC_COMPARE_JUMP_NOT_EQUAL 4'h4
`define BED_CYC_REL 4'h3
`define BED_CYC_XRAM 4'h2
`define BED_CYC_XSLOW 4'h4
`define BED_CYC_RET 4'h4
`define BED_CYC_RET_EXT 4'h5
`define BED_CYC_LCALL 4'h4
`define BED_CYC_LCALL_EXT 4'h6
`define BED_CYC_NOP2 4'h2
`define BED_ACC_RST 40'h00_0000_0000
`endif

/* bed_pkg.sv */
// types shared by the branch and escape decoder
package bed_pkg;
    typedef enum logic [2:0] {
        BED_ST_OP = 3'b000,
        BED_ST_ESC = 3'b001,
        BED_ST_ARG1 = 3'b010,
        BED_ST_ARG2 = 3'b011,
        BED_ST_WAIT = 3'b100
    } bed_state_t;
    typedef enum logic [2:0] {
        BED_K_NONE = 3'b000,
        BED_K_COMPARE_JUMP_NOT_EQUAL = 3'b001,
        BED_K_REL = 3'b010,
        BED_K_EXTERNAL_DATA_SPACE = 3'b011,
        BED_K_STACK = 3'b100
    } bed_kind_t;
    // core context presented to the decoder
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] ram_at_ri;
        logic debug_enable;
        logic pointer_select;
        logic ext_stack;
        logic slow_space;
    } bed_ctx_t;
endpackage

/* bed_prog_model.sv */
// program memory model that feeds the decoder one byte per fetch
`timescale 1ns/1ps
module bed_prog_model (
    // fetch address from the core
    input wire logic [15:0] pc_r,
    // byte presented at that address
    output logic [7:0] code_byte
);
    // ****************
    // code image
    // ****************
    logic [7:0] mem [0:255];
    // stores one byte at the low eight address bits, whatever its value, escape bytes included
    task automatic load(input logic [15:0] addr, input logic [7:0] data);
        mem[addr[7:0]] = data;
    endtask
    // plain no-op fill so running past an instruction stays harmless
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
    // combinational read: the byte at pc is settled well before the next edge
    assign code_byte = mem[pc_r[7:0]];
endmodule // bed_prog_model

/* bed_decoder_bench.sv */
// self-checking bench for the branch and escape decoder
`timescale 1ns/1ps
module bed_decoder_bench;
    // ****************
    // signals and helpers
    // ****************
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] code_byte;
    logic [15:0] pc_start = 16'h0000;
    bed_pkg::bed_ctx_t ctx = '0;
    logic [15:0] dptr0 = 16'h0000;
    logic [15:0] dptr1 = 16'h0000;
    logic mac_load = 1'b0;
    logic [39:0] mac_val = 40'h00_0000_0000;
    logic [15:0] pc_r, xaddr_r, ps;
    logic [39:0] mac_acc_r;
    logic carry_r, carry_we_r, debug_halt_r, busy_r, esc;
    bed_pkg::bed_ctx_t cx;
    logic [7:0] d, op;
    logic [7:0] esc_ops [0:4] = '{8'h00, 8'h03, 8'he4, 8'h5a, 8'hff};
    int seed = 87;
    int bad_count = 0;
    int check_count = 0;
    int k, kind, n;
    // free-running core clock, 10 ns period
    always #5 clk_sys = ~clk_sys;
    bed_decoder u_dut (.clk_sys(clk_sys), .reset(reset), .code_byte(code_byte),
        .pc_start(pc_start), .ctx(ctx), .dptr0(dptr0), .dptr1(dptr1),
        .mac_load(mac_load), .mac_load_val(mac_val), .pc_r(pc_r),
        .mac_acc_r(mac_acc_r), .carry_r(carry_r), .carry_we_r(carry_we_r),
        .debug_halt_r(debug_halt_r), .xaddr_r(xaddr_r), .busy_r(busy_r));
    bed_prog_model u_prog (.pc_r(pc_r), .code_byte(code_byte));
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // next pc offset: length plus sign-extended displacement
    function automatic logic [15:0] rel_off(input int len, input logic [7:0] disp);
        return 16'(len) + {{8{disp[7]}}, disp};
    endfunction
    // accumulate register after one instruction, starting from the loaded value
    function automatic logic [39:0] mac_exp(input logic [7:0] b0, input logic [7:0] b1,
        input logic [39:0] v);
        if (b0 != 8'ha5) return v;
        if (b1 == 8'h03) return {v[39], v[39:1]};
        if (b1 == 8'he4) return 40'h00_0000_0000;
        return v;
    endfunction
    // one instruction from a fresh reset, so every count starts at a known edge
    task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
        input int cyc, input logic [15:0] off, input int ewe, input logic ecar,
        input logic ehalt);
        int we;
        int bz;
        logic [39:0] mv;
        ps = 16'($random(seed));
        mv = {8'($random(seed)), 32'($random(seed))};
        u_prog.load(ps, b0);
        u_prog.load(ps + 16'h0001, b1);
        u_prog.load(ps + 16'h0002, b2);
        we = 0;
        bz = 0;
        @(posedge clk_sys);
        reset <= 1'b1;
        pc_start <= ps;
        ctx <= cx;
        dptr0 <= 16'($random(seed));
        dptr1 <= 16'($random(seed));
        mac_val <= mv;
        mac_load <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        mac_load <= 1'b0;
        repeat (cyc) begin
            @(posedge clk_sys);
            #1;
            we += int'(carry_we_r === 1'b1);
            bz += int'(busy_r === 1'b1);
        end
        chk(pc_r === ps + off, "pc after instruction");
        chk(debug_halt_r === ehalt, "debug halt");
        chk(mac_acc_r === mac_exp(b0, b1, mv), "accumulate register");
        chk(bz == cyc - 1, "busy cycles");
        chk(busy_r === 1'b0, "busy after instruction");
        if (ewe >= 0) chk(we == ewe, "carry write count");
        if (ewe == 1) chk(carry_r === ecar, "carry value");
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        cx = '0;
        run(8'ha5, 8'h03, 8'h00, 2, 16'h0002, 0, 1'b0, 1'b0);
        run(8'ha5, 8'he4, 8'h00, 2, 16'h0002, 0, 1'b0, 1'b0);
        run(8'ha5, 8'h00, 8'h00, 2, 16'h0002, 0, 1'b0, 1'b0);
        cx.debug_enable = 1'b1;
        run(8'ha5, 8'h00, 8'ha5, 2, 16'h0002, 0, 1'b0, 1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk((pc_r === ps + 16'h0002) && (debug_halt_r === 1'b1), "frozen after halt");
        cx.debug_enable = 1'b0;
        cx.acc = 8'h5c;
        cx.ram_at_ri = 8'h5c;
        run(8'ha5, 8'hb6, 8'h80, 4, 16'h0003, 1, 1'b0, 1'b0);
        cx.acc = 8'h34;
        cx.ram_at_ri = 8'h56;
        run(8'ha5, 8'hb7, 8'h7f, 4, rel_off(3, 8'h7f), 1, 1'b1, 1'b0);
        // random mix of every kind of instruction this slice decodes
        for (k = 0; k < 40; k++) begin
            kind = {$random(seed)} % 6;
            d = 8'($random(seed));
            cx.acc = 8'($random(seed));
            cx.ram_at_ri = k[0] ? cx.acc : 8'($random(seed));
            cx.pointer_select = 1'($random(seed));
            cx.slow_space = 1'($random(seed));
            cx.ext_stack = 1'($random(seed));
            case (kind)
                0: run(8'h80, d, 8'h00, 3, rel_off(2, d), 0, 1'b0, 1'b0);
                1: begin
                    op = 8'hb6 | {7'h00, d[0]};
                    run(8'ha5, op, d, 4, (cx.acc != cx.ram_at_ri) ? rel_off(3, d) : 16'h0003,
                        1, cx.acc < cx.ram_at_ri, 1'b0);
                end
                2: begin
                    op = d[2] ? (8'hb8 | {5'h00, d[5:3]}) : {6'h2d, d[4:3]};
                    run(op, 8'h00, d, 4, rel_off(3, d), -1, 1'b0, 1'b0);
                end
                3: run(8'ha5, esc_ops[d % 5], 8'h00, 2, 16'h0002, 0, 1'b0, 1'b0);
                5: begin
                    op = d[1] ? 8'h22 : 8'h12;
                    n = d[1] ? (cx.ext_stack ? 5 : 4) : (cx.ext_stack ? 6 : 4);
                    run(op, 8'h00, 8'h00, n, 16'h0001, 0, 1'b0, 1'b0);
                end
                default: begin
                    esc = d[0];
                    op = d[1] ? 8'he0 : 8'hf0;
                    n = (esc ? 3 : 2) + (cx.slow_space ? 2 : 0);
                    run(esc ? 8'ha5 : op, esc ? op : 8'h00, 8'h00, n,
                        esc ? 16'h0002 : 16'h0001, 0, 1'b0, 1'b0);
                    chk(xaddr_r === ((esc ^ cx.pointer_select) ? dptr1 : dptr0), "xaddr");
                end
            endcase
        end
        test_done;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        bad_count++;
        $display("FAIL %0t run did not finish", $time);
        test_done;
    end
endmodule // bed_decoder_bench
